/* File: inc/sfl_link_consts.svh */
// Offsets, field positions, reset values and timing of the serial link.
// Assumes a 125 MHz system clock and word-aligned Avalon-MM byte addresses.
`ifndef SFL_LINK_CONSTS_SVH
`define SFL_LINK_CONSTS_SVH
`define SFL_CLK_HZ 125000000
// Register word indices (byte address = index * 4)
`define SFL_W_CTRL 4'h0
`define SFL_W_STATION 4'h1
`define SFL_W_STATUS 4'h2
`define SFL_W_ACTIVE 4'h3
`define SFL_W_RXDATA 4'h4
`define SFL_W_TXDATA 4'h5
// Control word fields
`define SFL_F_PROTO 1:0
`define SFL_F_RATE 4:2
`define SFL_F_FRAME 6:5
`define SFL_F_PROF 8:7
`define SFL_CTRL_RST 9'h00c
`define SFL_STATION_RST 16'h0001
`define SFL_MAP_RST 16'h0000
// Protocol select codes
`define SFL_PROTO_NONE 2'h0
`define SFL_PROTO_MULTI 2'h1
`define SFL_PROTO_EXT 2'h2
`define SFL_PROTO_P2P 2'h3
// Framing codes: 8N1, 8N2, 8E1, 8O1
`define SFL_FR_8N2 2'h1
`define SFL_FR_8O1 2'h3
// Status bits
`define SFL_S_PERR 5
`define SFL_S_OVR 6
// Bit rates in bit/s, rate codes 0..7
`define SFL_RATE0 1200
`define SFL_RATE1 2400
`define SFL_RATE2 4800
`define SFL_RATE3 9600
`define SFL_RATE4 19200
`define SFL_RATE5 38400
`define SFL_RATE6 57600
`define SFL_RATE7 76800
// Silent bit times that end a frame (3.5 characters of 11 bits)
`define SFL_GAP_BITS 23'h26
`endif

/* File: inc/sfl_pkg.sv */
// Types and shared helpers of the serial link slave.
// Assumes the constants header sits on the include path.
`include "sfl_link_consts.svh"
package sfl_pkg;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
      sfl_rx_e;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
      sfl_tx_e;

   function automatic logic sfl_par_en(input logic [1:0] fr);
      return fr[1];
   endfunction : sfl_par_en

   function automatic logic sfl_par_odd(input logic [1:0] fr);
      return fr == `SFL_FR_8O1;
   endfunction : sfl_par_odd

   function automatic logic [16:0] sfl_bit_div(input int unsigned clk_hz,
                                               input logic [2:0] code);
      int unsigned rate;
      rate = `SFL_RATE0;
      unique case (code)
         3'h0: rate = `SFL_RATE0;
         3'h1: rate = `SFL_RATE1;
         3'h2: rate = `SFL_RATE2;
         3'h3: rate = `SFL_RATE3;
         3'h4: rate = `SFL_RATE4;
         3'h5: rate = `SFL_RATE5;
         3'h6: rate = `SFL_RATE6;
         3'h7: rate = `SFL_RATE7;
      endcase
      return 17'(clk_hz / rate);
   endfunction : sfl_bit_div
endpackage : sfl_pkg

/* File: rtl/sfl_rx.sv */
// Character receiver: start, 8 data bits LSB first, optional parity, stop.
// Assumes i_rxd is already synchronised to i_clock.
`timescale 1ns/100ps
module sfl_rx
   import sfl_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_enable,
   input wire logic i_rxd,
   input wire logic [16:0] i_divisor,
   input wire logic [1:0] i_framing,
   output logic o_busy,
   output logic o_valid,
   output logic [7:0] o_data,
   output logic o_err
);
   sfl_rx_e state_r;
   logic [16:0] cnt_r;
   logic [2:0] bit_r;
   logic [7:0] sh_r;
   logic par_r;

   assign o_busy = state_r != RX_IDLE;

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_r <= RX_IDLE;
         cnt_r <= 17'h0;
         bit_r <= 3'h0;
         sh_r <= 8'h0;
         par_r <= 1'b0;
         o_valid <= 1'b0;
         o_data <= 8'h0;
         o_err <= 1'b0;
      end
      else
      begin
         o_valid <= 1'b0;
         unique case (state_r)
            RX_IDLE:
               if (i_enable && !i_rxd)
               begin
                  state_r <= RX_START;
                  cnt_r <= {1'b0, i_divisor[16:1]};
               end
            RX_START:
               if (cnt_r != 17'h0)
                  cnt_r <= cnt_r - 17'h1;
               else if (i_rxd)
                  state_r <= RX_IDLE; // Glitch, not a start bit
               else
               begin
                  state_r <= RX_DATA;
                  cnt_r <= i_divisor - 17'h1;
                  bit_r <= 3'h0;
               end
            RX_DATA:
               if (cnt_r != 17'h0)
                  cnt_r <= cnt_r - 17'h1;
               else
               begin
                  sh_r <= {i_rxd, sh_r[7:1]};
                  cnt_r <= i_divisor - 17'h1;
                  bit_r <= bit_r + 3'h1;
                  if (bit_r == 3'h7)
                     state_r <= sfl_par_en(i_framing) ? RX_PAR : RX_STOP;
               end
            RX_PAR:
               if (cnt_r != 17'h0)
                  cnt_r <= cnt_r - 17'h1;
               else
               begin
                  par_r <= i_rxd;
                  cnt_r <= i_divisor - 17'h1;
                  state_r <= RX_STOP;
               end
            RX_STOP:
               if (cnt_r != 17'h0)
                  cnt_r <= cnt_r - 17'h1;
               else
               begin
                  // Only the first stop bit is checked, so 8N2 peers pass
                  o_valid <= 1'b1;
                  o_data <= sh_r;
                  o_err <= !i_rxd || (sfl_par_en(i_framing) &&
                     ((^sh_r ^ par_r) != sfl_par_odd(i_framing)));
                  state_r <= RX_IDLE;
               end
         endcase
      end
   end

   rx_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_enable && state_r == RX_IDLE |=> state_r == RX_IDLE)
      else $error("receiver started while disabled");
endmodule : sfl_rx

/* File: rtl/sfl_tx.sv */
// Character transmitter with parity and one or two stop bits.
// Assumes i_start is only raised while o_busy is low.
`timescale 1ns/100ps
module sfl_tx
   import sfl_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire logic [7:0] i_data,
   input wire logic [16:0] i_divisor,
   input wire logic [1:0] i_framing,
   output logic o_busy,
   output logic o_txd
);
   sfl_tx_e state_r;
   logic [16:0] cnt_r;
   logic [2:0] bit_r;
   logic [7:0] sh_r;
   logic par_r;
   logic stop2_r;

   assign o_busy = state_r != TX_IDLE;

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_r <= TX_IDLE;
         cnt_r <= 17'h0;
         bit_r <= 3'h0;
         sh_r <= 8'h0;
         par_r <= 1'b0;
         stop2_r <= 1'b0;
         o_txd <= 1'b1;
      end
      else if (state_r == TX_IDLE)
      begin
         o_txd <= 1'b1;
         if (i_start)
         begin
            sh_r <= i_data;
            par_r <= ^i_data ^ sfl_par_odd(i_framing);
            cnt_r <= i_divisor - 17'h1;
            o_txd <= 1'b0;
            state_r <= TX_START;
         end
      end
      else if (cnt_r != 17'h0)
         cnt_r <= cnt_r - 17'h1;
      else
      begin
         cnt_r <= i_divisor - 17'h1;
         unique case (state_r)
            TX_START:
            begin
               o_txd <= sh_r[0];
               sh_r <= {1'b0, sh_r[7:1]};
               bit_r <= 3'h0;
               state_r <= TX_DATA;
            end
            TX_DATA:
               if (bit_r != 3'h7)
               begin
                  o_txd <= sh_r[0];
                  sh_r <= {1'b0, sh_r[7:1]};
                  bit_r <= bit_r + 3'h1;
               end
               else if (sfl_par_en(i_framing))
               begin
                  o_txd <= par_r;
                  state_r <= TX_PAR;
               end
               else
               begin
                  o_txd <= 1'b1;
                  stop2_r <= i_framing == `SFL_FR_8N2;
                  state_r <= TX_STOP;
               end
            TX_PAR:
            begin
               o_txd <= 1'b1;
               stop2_r <= 1'b0;
               state_r <= TX_STOP;
            end
            TX_STOP:
               if (stop2_r)
                  stop2_r <= 1'b0;
               else
                  state_r <= TX_IDLE;
            TX_IDLE:
               state_r <= TX_IDLE;
         endcase
      end
   end

   tx_bit_time_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      o_busy |-> cnt_r < i_divisor)
      else $error("bit counter beyond bit period");
   tx_stop_high_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      state_r == TX_STOP |-> o_txd)
      else $error("stop bit not high");
endmodule : sfl_tx

/* File: rtl/sfl_link_top.sv */
// Serial fieldbus slave: settings registers, apply logic, frame filter.
// Assumes an Avalon-MM master and an RS-232/RS-485 transceiver on the pins.
//
// Overview of operation
// - Slave exchanges asynchronous serial characters with one external master.
// - Half-duplex: never transmit while a request is still arriving.
// - Link active only for multipoint or point-to-point protocol choice.
// - Station address 0 to 65535, unique on the line; frames match only stations 0 to 255.
// - Bit rates 1.2 to 76.8 kbit/s in eight steps, both directions.
// - Framing 8N1, 8N2, 8E1 or 8O1; all stations identical.
// - Profile setting picks limited standard, full standard or alternative.
// - Eight slots, each 0 to 65535, pick mapped actual values.
// - New settings apply at power-up or after address cleared and rewritten.
`timescale 1ns/100ps
`include "sfl_link_consts.svh"
module sfl_link_top
   import sfl_pkg::*;
#(
   parameter int unsigned P_CLK_HZ = `SFL_CLK_HZ
)
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_rxd,
   output logic o_txd,
   output logic o_tx_oe,
   output logic o_link_active,
   output logic [1:0] o_control_profile,
   output logic [127:0] o_map_slots
);
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            res[8*i +: 8] = wd[8*i +: 8];
      return res;
   endfunction : be_merge

   logic ack_r;
   logic [3:0] word;
   logic wr_go;
   logic [31:0] rd_mux;
   logic [8:0] ctrl_r;
   logic [15:0] station_r;
   logic [15:0] map_r [0:7];
   logic [8:0] act_ctrl_r;
   logic [15:0] act_station_r;
   logic [15:0] act_map_r [0:7];
   logic pwr_r;
   logic armed_r;
   logic apply_r;
   logic [31:0] st_nxt;
   logic rxd_meta_r;
   logic rxd_sync_r;
   logic [16:0] bit_div;
   logic [22:0] gap_lim;
   logic [22:0] gap_cnt_r;
   logic gap_done_r;
   logic rx_busy;
   logic rx_v;
   logic [7:0] rx_byte;
   logic rx_err;
   logic tx_busy;
   logic tx_start;
   logic first_r;
   logic frame_ok_r;
   logic match;
   logic deliver;
   logic rd_cap;
   logic [8:0] rx_data_r;
   logic rx_valid_r;
   logic perr_r;
   logic ovr_r;

   // One wait state: read data is registered in the first cycle
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
   assign word = i_avs_address[5:2];
   assign wr_go = i_avs_write && ack_r;
   assign rd_cap = i_avs_read && !ack_r && word == `SFL_W_RXDATA;
   assign st_nxt = be_merge({16'h0, station_r}, i_avs_writedata,
                            i_avs_byteenable);

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         ack_r <= 1'b0;
      else
         ack_r <= o_avs_waitrequest;
   end

   always_comb
   begin
      rd_mux = 32'h0;
      if (word[3])
         rd_mux = {16'h0, map_r[word[2:0]]};
      else
         case (word)
            `SFL_W_CTRL: rd_mux = {23'h0, ctrl_r};
            `SFL_W_STATION: rd_mux = {16'h0, station_r};
            `SFL_W_STATUS: rd_mux = {25'h0, ovr_r, perr_r, frame_ok_r,
               rx_valid_r, tx_busy, rx_busy, o_link_active};
            `SFL_W_ACTIVE: rd_mux = {act_station_r, 7'h0, act_ctrl_r};
            `SFL_W_RXDATA: rd_mux = {22'h0, rx_valid_r, rx_data_r};
            default: rd_mux = 32'h0;
         endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_avs_readdata <= 32'h0;
      else if (i_avs_read && !ack_r)
         o_avs_readdata <= rd_mux;
   end

   // Shadow settings written by software
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ctrl_r <= `SFL_CTRL_RST;
         station_r <= `SFL_STATION_RST;
         for (int i = 0; i < 8; i++)
            map_r[i] <= `SFL_MAP_RST;
      end
      else if (wr_go)
      begin
         if (word[3])
            map_r[word[2:0]] <= 16'(be_merge({16'h0, map_r[word[2:0]]},
               i_avs_writedata, i_avs_byteenable));
         else if (word == `SFL_W_CTRL)
            ctrl_r <= 9'(be_merge({23'h0, ctrl_r}, i_avs_writedata,
               i_avs_byteenable));
         else if (word == `SFL_W_STATION)
            station_r <= st_nxt[15:0];
      end
   end

   // Apply at power-up and on a station write that follows a cleared one
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         pwr_r <= 1'b1;
         armed_r <= 1'b0;
         apply_r <= 1'b0;
      end
      else
      begin
         pwr_r <= 1'b0;
         apply_r <= wr_go && word == `SFL_W_STATION && armed_r;
         if (wr_go && word == `SFL_W_STATION)
            armed_r <= st_nxt[15:0] == 16'h0;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         act_ctrl_r <= `SFL_CTRL_RST;
         act_station_r <= `SFL_STATION_RST;
         for (int i = 0; i < 8; i++)
            act_map_r[i] <= `SFL_MAP_RST;
      end
      else if (pwr_r || apply_r)
      begin
         act_ctrl_r <= ctrl_r;
         act_station_r <= station_r;
         for (int i = 0; i < 8; i++)
            act_map_r[i] <= map_r[i];
      end
   end

   assign o_link_active = act_ctrl_r[`SFL_F_PROTO] == `SFL_PROTO_MULTI ||
      act_ctrl_r[`SFL_F_PROTO] == `SFL_PROTO_P2P;
   assign o_control_profile = act_ctrl_r[`SFL_F_PROF];
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         o_map_slots[16*i +: 16] = act_map_r[i];
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rxd_meta_r <= 1'b1;
         rxd_sync_r <= 1'b1;
      end
      else
      begin
         rxd_meta_r <= i_rxd;
         rxd_sync_r <= rxd_meta_r;
      end
   end

   assign bit_div = sfl_bit_div(P_CLK_HZ, act_ctrl_r[`SFL_F_RATE]);
   assign gap_lim = {6'h0, bit_div} * `SFL_GAP_BITS;

   // Own echo is ignored: the receiver is off while transmitting
   sfl_rx u_rx (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_enable(o_link_active && !tx_busy && !tx_start),
      .i_rxd(rxd_sync_r),
      .i_divisor(bit_div),
      .i_framing(act_ctrl_r[`SFL_F_FRAME]),
      .o_busy(rx_busy),
      .o_valid(rx_v),
      .o_data(rx_byte),
      .o_err(rx_err)
   );

   // Line silence marks frame boundaries
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         gap_cnt_r <= 23'h0;
         gap_done_r <= 1'b0;
      end
      else if (rx_busy || rx_v)
      begin
         gap_cnt_r <= 23'h0;
         gap_done_r <= 1'b0;
      end
      else if (gap_cnt_r >= gap_lim)
         gap_done_r <= 1'b1;
      else
         gap_cnt_r <= gap_cnt_r + 23'h1;
   end

   assign match = {8'h0, rx_byte} == act_station_r;
   assign deliver = rx_v && (first_r ? match : frame_ok_r);

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         first_r <= 1'b1;
         frame_ok_r <= 1'b0;
      end
      else if (!o_link_active)
      begin
         first_r <= 1'b1;
         frame_ok_r <= 1'b0;
      end
      else if (rx_v)
      begin
         first_r <= 1'b0;
         if (first_r)
            frame_ok_r <= match;
      end
      else if (gap_done_r)
         first_r <= 1'b1;
   end

   // Receive data and sticky flags; a new event wins over a clear
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rx_data_r <= 9'h0;
         rx_valid_r <= 1'b0;
         perr_r <= 1'b0;
         ovr_r <= 1'b0;
      end
      else
      begin
         if (rd_cap)
            rx_valid_r <= 1'b0;
         if (wr_go && word == `SFL_W_STATUS && i_avs_byteenable[0])
         begin
            if (i_avs_writedata[`SFL_S_PERR])
               perr_r <= 1'b0;
            if (i_avs_writedata[`SFL_S_OVR])
               ovr_r <= 1'b0;
         end
         if (deliver)
         begin
            rx_data_r <= {first_r, rx_byte};
            rx_valid_r <= 1'b1;
            if (rx_valid_r && !rd_cap)
               ovr_r <= 1'b1;
            if (rx_err)
               perr_r <= 1'b1;
         end
      end
   end

   // Writes that would break half-duplex or address a foreign frame are lost
   assign tx_start = wr_go && word == `SFL_W_TXDATA && o_link_active &&
      !rx_busy && gap_done_r && frame_ok_r && !tx_busy;

   sfl_tx u_tx (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_start(tx_start),
      .i_data(i_avs_writedata[7:0]),
      .i_divisor(bit_div),
      .i_framing(act_ctrl_r[`SFL_F_FRAME]),
      .o_busy(tx_busy),
      .o_txd(o_txd)
   );

   assign o_tx_oe = tx_busy && o_link_active;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);

   link_gate_a: assert property (!o_link_active |-> !o_tx_oe)
      else $error("driver enabled while link inactive");
   half_duplex_a: assert property (rx_busy |-> !o_tx_oe)
      else $error("line driver enabled during reception");
   addr_silent_a: assert property (tx_start |-> frame_ok_r ##1 o_tx_oe)
      else $error("reply to a foreign frame or no driver");
   apply_hold_a: assert property (!(pwr_r || apply_r) |=>
      $stable(act_ctrl_r) && $stable(act_station_r))
      else $error("settings changed without apply");
   apply_take_a: assert property (apply_r |=>
      act_station_r == $past(station_r) && act_ctrl_r == $past(ctrl_r))
      else $error("apply did not copy settings");
   map_out_a: assert property (apply_r |=>
      o_map_slots[127:112] == $past(map_r[7]))
      else $error("map slot not applied");
   profile_out_a: assert property (apply_r |=>
      o_control_profile == $past(ctrl_r[8:7]))
      else $error("profile not applied");
   bus_answer_a: assert property ((i_avs_read || i_avs_write) && !ack_r
      |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("bus answer not after one wait state");

   reply_sent_c: cover property (tx_start);
   foreign_frame_c: cover property (rx_v && first_r && !match);
   readdress_c: cover property (apply_r);
   char_err_c: cover property (deliver && rx_err);
endmodule : sfl_link_top

/* File: tb/sfl_master_model.sv */
// Serial master on the far side of the link pins, driven by bench calls.
// Assumes bit periods are given in i_clock cycles; idle line is high.
`timescale 1ns/100ps
module sfl_master_model
(
   input wire logic i_clock,
   input wire logic i_txd,
   input wire logic i_tx_oe,
   output logic o_rxd
);
   initial o_rxd = 1'b1;

   // Called only while the slave is silent; single master on the line
   task automatic send_byte(input logic [7:0] d, input int dv,
                            input logic [1:0] fr);
      logic [10:0] bits;
      int n;
      bits = {1'b1, ^d ^ (fr == 2'h3), d, 1'b0};
      if (fr[1] == 1'b0)
         bits[9] = 1'b1;
      n = (fr == 2'h0) ? 10 : 11;
      for (int i = 0; i < n; i++)
      begin
         @(posedge i_clock);
         o_rxd <= bits[i];
         repeat (dv - 1) @(posedge i_clock);
      end
      // Line stays idle until the slave's synchroniser and stop sample land
      repeat (4) @(posedge i_clock);
   endtask : send_byte

   // Sampled on the falling edge to stay clear of the launch edge
   task automatic recv_byte(input int dv, input logic [1:0] fr,
                            output logic [7:0] d, output logic bad,
                            output int len, output logic oe);
      int w;
      w = 0;
      len = 0;
      @(negedge i_clock);
      while (i_txd === 1'b1 && w < 400)
      begin
         @(negedge i_clock);
         w++;
      end
      oe = i_tx_oe;
      while (i_txd === 1'b0 && len < 2000)
      begin
         @(negedge i_clock);
         len++;
      end
      repeat (dv / 2 - 1) @(negedge i_clock);
      for (int i = 0; i < 8; i++)
      begin
         d[i] = i_txd;
         repeat (dv) @(negedge i_clock);
      end
      bad = 1'b0;
      if (fr[1])
      begin
         bad = i_txd !== (^d ^ (fr == 2'h3));
         repeat (dv) @(negedge i_clock);
      end
      bad = bad | (i_txd !== 1'b1);
   endtask : recv_byte
endmodule : sfl_master_model

/* File: tb/sfl_link_top_tb_top.sv */
// Bench for the serial link slave: register access plus serial traffic.
// Assumes the design and the master model are compiled before this file.
`timescale 1ns/100ps
`include "sfl_link_consts.svh"
module sfl_link_top_tb_top;
   // Slow clock figure keeps bit periods short: 4 cycles at 76.8k
   localparam int unsigned CLK_HZ = 307200;
   logic i_clock, i_rst_b, i_avs_read, i_avs_write, i_rxd;
   logic [5:0] i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, rdata;
   logic [3:0] i_avs_byteenable;
   logic o_avs_waitrequest, o_txd, o_tx_oe, o_link_active;
   logic [1:0] o_control_profile;
   logic [127:0] o_map_slots;
   logic [7:0] rx_d;
   logic rx_bad, rx_oe;
   int rx_len, dv, cycles, mismatches, compares;
   int rate_tab [0:7] = '{`SFL_RATE0, `SFL_RATE1, `SFL_RATE2, `SFL_RATE3,
                          `SFL_RATE4, `SFL_RATE5, `SFL_RATE6, `SFL_RATE7};

   sfl_link_top #(.P_CLK_HZ(CLK_HZ)) u_sfl_link_top (.i_clock(i_clock),
      .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_rxd(i_rxd),
      .o_txd(o_txd), .o_tx_oe(o_tx_oe), .o_link_active(o_link_active),
      .o_control_profile(o_control_profile), .o_map_slots(o_map_slots));

   // Zero-delay wire stands for a short point-to-point cable
   sfl_master_model u_sfl_master_model (.i_clock(i_clock), .i_txd(o_txd),
      .i_tx_oe(o_tx_oe), .o_rxd(i_rxd));

   always #4 i_clock = ~i_clock;

   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 80000)
      begin
         mismatches++;
         summarize();
      end
   end

   task automatic summarize();
      if (mismatches == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic [5:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge i_clock);
      i_avs_address <= a;
      i_avs_write <= w;
      i_avs_read <= !w;
      i_avs_writedata <= d;
      do
         @(posedge i_clock);
      while (o_avs_waitrequest !== 1'b0);
      rdata = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [5:0] a);
      bus(a, 1'b0, 32'h0);
   endtask : rd

   function automatic logic [31:0] cw(input logic [1:0] pr,
      input logic [2:0] rt, input logic [1:0] fr, input logic [1:0] pf);
      return {23'h0, pf, fr, rt, pr};
   endfunction : cw

   // Station cleared then rewritten makes pending settings live
   task automatic apply(input logic [15:0] st);
      wr(6'h04, 32'h0);
      wr(6'h04, {16'h0, st});
      repeat (2) @(posedge i_clock);
   endtask : apply

   task automatic gap(input int d);
      repeat (40 * d) @(posedge i_clock);
   endtask : gap

   // Address byte in, then one answer byte out
   task automatic frame(input int d, input logic [1:0] fr);
      gap(d);
      u_sfl_master_model.send_byte(8'h05, d, fr);
      rd(6'h10);
      chk(rdata, 32'h305);
      gap(d);
      fork
         u_sfl_master_model.recv_byte(d, fr, rx_d, rx_bad, rx_len, rx_oe);
         wr(6'h14, 32'h5b);
      join
      chk(32'(rx_d), 32'h5b);
      chk(32'(rx_bad), 32'h0);
      chk(32'(rx_oe), 32'h1);
   endtask : frame

   initial
   begin
      i_clock = 1'b0;
      i_rst_b = 1'b0;
      i_avs_address = 6'h00;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_writedata = 32'h0;
      i_avs_byteenable = 4'hf;
      cycles = 0;
      mismatches = 0;
      compares = 0;
      repeat (6) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd(6'h00);
      chk(rdata, 32'h00c);
      chk(32'(o_link_active), 32'h0);
      rd(6'h0c);
      chk(rdata, 32'h0001000c);
      rd(6'h18);
      chk(rdata, 32'h0);
      wr(6'h20, 32'hbeef);
      wr(6'h3c, 32'h1234);
      wr(6'h00, cw(2'h1, 3'h7, 2'h0, 2'h2));
      wr(6'h04, 32'h5);
      chk(32'(o_link_active), 32'h0);
      chk(o_map_slots[31:0], 32'h0);
      apply(16'h5);
      chk(32'(o_link_active), 32'h1);
      chk(32'(o_control_profile), 32'h2);
      chk(o_map_slots[31:0], 32'hbeef);
      chk(32'(o_map_slots[127:112]), 32'h1234);
      apply(16'hffff);
      rd(6'h0c);
      chk(rdata, 32'hffff011d);
      for (int p = 0; p < 4; p++)
      begin
         wr(6'h00, cw(2'(p), 3'h7, 2'h0, 2'(p % 3)));
         apply(16'h5);
         chk(32'(o_link_active), 32'(p % 2));
         chk(32'(o_control_profile), 32'(p % 3));
      end
      gap(4);
      u_sfl_master_model.send_byte(8'h09, 4, 2'h0);
      rd(6'h10);
      chk(32'(rdata[9]), 32'h0);
      gap(4);
      u_sfl_master_model.send_byte(8'h05, 4, 2'h0);
      rd(6'h10);
      chk(rdata, 32'h305);
      u_sfl_master_model.send_byte(8'ha6, 4, 2'h0);
      rd(6'h10);
      chk(rdata, 32'h2a6);
      fork
         u_sfl_master_model.send_byte(8'h33, 4, 2'h0);
         begin
            repeat (20) @(posedge i_clock);
            wr(6'h14, 32'h77);
         end
      join
      chk(32'(o_tx_oe), 32'h0);
      rd(6'h10);
      for (int f = 0; f < 4; f++)
      begin
         wr(6'h00, cw(2'h3, 3'h7, 2'(f), 2'h0));
         apply(16'h5);
         frame(4, 2'(f));
      end
      for (int r = 0; r < 8; r++)
      begin
         dv = int'(CLK_HZ) / rate_tab[r];
         wr(6'h00, cw(2'h3, 3'(r), 2'h0, 2'h0));
         apply(16'h5);
         frame(dv, 2'h0);
         chk(32'(rx_len), 32'(dv));
      end
      rd(6'h08);
      chk(32'(rdata[6:5]), 32'h0);
      summarize();
   end
endmodule : sfl_link_top_tb_top
